/* rtl/amsp_top.sv */
module amsp_top (
    input  logic                       clk,
    input  logic                       resetn,
    input  logic                       shift_clk,
    input  logic                       channel_select_n,
    input  logic                       converter_select_n,
    input  logic                       serial_in,
    input  amsp_pkg::amsp_result_t     result_in,
    output logic                       result_ready,
    output logic                       convert_start,
    output logic                       converter_power,
    output logic                       sample_active,
    output logic [amsp_pkg::CHAN_N-1:0] channel_enable,
    output logic                       serial_out,
    output logic                       serial_out_en
);
    import amsp_pkg::*;

    // ==================================================================
    // state
    amsp_state_t     st_q;
    amsp_state_t     st_d;
    logic            sclk_rise;
    logic            sclk_fall;
    logic            ch_fall;
    logic            cv_fall;
    logic            cv_rise;
    logic            push;
    logic            pop;
    logic [FC_W-1:0] fc_n;

    // ==================================================================
    // next state
    always_comb begin
        st_d      = st_q;
        st_d.start = 1'b0;
        fc_n      = st_q.fc;
        // shift clock and selects are synchronous inputs: plain edge detect
        sclk_rise = shift_clk & ~st_q.sclk;
        sclk_fall = ~shift_clk & st_q.sclk;
        ch_fall   = ~channel_select_n & st_q.ch_sel;
        cv_fall   = ~converter_select_n & st_q.cv_sel;
        cv_rise   = converter_select_n & ~st_q.cv_sel;
        st_d.sclk   = shift_clk;
        st_d.ch_sel = channel_select_n;
        st_d.cv_sel = converter_select_n;

        // channel word: oldest bit ends up in the enable slot
        if (channel_select_n && sclk_rise) begin
            st_d.word = {st_q.word[WORD_W-2:0], serial_in};
        end

        // break-before-make sequencer
        case (st_q.mux)
            MUX_BREAK: begin
                if (st_q.tmr == '0) begin
                    st_d.chan = '0;
                    if (st_q.latched[EN_POS]) begin
                        st_d.mux = MUX_GAP;
                        st_d.tmr = OPEN_LOAD;
                    end else begin
                        st_d.mux = MUX_IDLE;
                    end
                end else begin
                    st_d.tmr = st_q.tmr - 1'b1;
                end
            end
            MUX_GAP: begin
                if (st_q.tmr == '0) begin
                    st_d.chan = amsp_decode(st_q.latched[CODE_W-1:0]);
                    st_d.mux  = MUX_HOLD;
                end else begin
                    st_d.tmr = st_q.tmr - 1'b1;
                end
            end
            default: begin
            end
        endcase
        // a fresh fall restarts the break even mid-sequence
        if (ch_fall) begin
            st_d.latched = st_q.word;
            st_d.mux     = MUX_BREAK;
            st_d.tmr     = OFF_LOAD;
        end

        // converter side and serial output
        if (converter_select_n) begin
            st_d.power  = 1'b0;
            st_d.want   = 1'b0;
            st_d.loaded = 1'b0;
            st_d.fc     = '0;
            st_d.soe    = 1'b0;
            st_d.sout   = 1'b0;
        end else if (cv_fall) begin
            st_d.power = 1'b1;
            st_d.fc    = '0;
        end else if (sclk_fall) begin
            // while selected, serial output changes happen on falling shift clock
            fc_n    = (st_q.fc == FC_MAX) ? st_q.fc : st_q.fc + 4'h1;
            st_d.fc = fc_n;
            if (fc_n == FC_NULL) begin
                st_d.soe  = 1'b1;
                st_d.sout = 1'b0;
            end
            if (fc_n == FC_SAMPLE_END) begin
                st_d.start = 1'b1;
                st_d.want  = 1'b1;
            end
            if (fc_n > FC_SAMPLE_END && fc_n <= FC_LAST) begin
                // a late result reads as zeros rather than stalling the link
                st_d.sout = st_q.loaded & st_q.sh[FC_LAST - fc_n];
            end else if (fc_n > FC_LAST) begin
                st_d.sout = 1'b0;
            end
        end
        st_d.sample = ~converter_select_n & (st_d.fc < FC_SAMPLE_END)
                      & (st_d.mux != MUX_BREAK) & (st_d.mux != MUX_GAP);

        // two-entry result buffer
        push = result_in.valid & st_q.rdy;
        pop  = st_q.want & (st_q.cnt != 2'h0) & ~converter_select_n;
        if (push) begin
            st_d.fifo[st_q.wp] = result_in.data;
            st_d.wp            = ~st_q.wp;
        end
        if (pop) begin
            st_d.sh     = st_q.fifo[st_q.rp];
            st_d.rp     = ~st_q.rp;
            st_d.loaded = 1'b1;
            st_d.want   = 1'b0;
            st_d.power  = 1'b0;
        end
        st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
        // results left over from the old exchange are dropped
        if (cv_rise) begin
            st_d.rp  = st_d.wp;
            st_d.cnt = 2'h0;
        end
        st_d.rdy = (st_d.cnt != BUF_FULL);
    end

    // ==================================================================
    // registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign result_ready    = st_q.rdy;
    assign convert_start   = st_q.start;
    assign converter_power = st_q.power;
    assign sample_active   = st_q.sample;
    assign channel_enable  = st_q.chan;
    assign serial_out      = st_q.sout;
    assign serial_out_en   = st_q.soe;

    // ==================================================================
    // assertions
    localparam int OFF_A = OFF_CYC;
    localparam int ON_A  = ON_CYC;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    out_float_a: assert property (
        converter_select_n |=> !serial_out_en)
        else $error("output driven while converter deselected");

    word_shift_a: assert property (
        (channel_select_n && shift_clk && !st_q.sclk)
        |=> st_q.word == {$past(st_q.word[WORD_W-2:0]), $past(serial_in)})
        else $error("channel word did not shift");

    word_hold_a: assert property (
        !channel_select_n |=> $stable(st_q.word))
        else $error("channel word changed while selected");

    break_off_a: assert property (
        $fell(channel_select_n) |-> ##OFF_A (channel_enable == '0))
        else $error("channels not off after off delay");

    make_on_a: assert property (
        ($fell(channel_select_n) && st_q.word[EN_POS])
        |-> ##ON_A channel_enable
            == amsp_decode($past(st_q.word[CODE_W-1:0], ON_A)))
        else $error("channel not connected after on delay");

    all_off_a: assert property (
        ($fell(channel_select_n) && !st_q.word[EN_POS])
        |-> ##ON_A (channel_enable == '0))
        else $error("channel on while enable bit clear");

    null_bit_a: assert property (
        $rose(serial_out_en) |-> !serial_out)
        else $error("first driven bit not null");

    drive_sel_a: assert property (
        serial_out_en |-> $past(!converter_select_n))
        else $error("line driven without select low");

    sample_end_a: assert property (
        convert_start |-> !sample_active && !serial_out && serial_out_en)
        else $error("conversion start out of place");

    power_up_a: assert property (
        $fell(converter_select_n) |=> converter_power)
        else $error("converter not powered on select low");

    power_down_a: assert property (
        $rose(st_q.loaded) |-> !converter_power)
        else $error("converter still powered after result");

    msb_first_a: assert property (
        (!converter_select_n && !shift_clk && st_q.sclk
         && st_q.fc == FC_SAMPLE_END && st_q.loaded)
        |=> serial_out == $past(st_q.sh[RES_W-1]))
        else $error("result not sent msb first");

    chan_on_c:  cover property ($rose(|channel_enable));
    start_c:    cover property (convert_start);
    buf_full_c: cover property (!result_ready && result_in.valid);
    last_bit_c: cover property (st_q.fc == FC_LAST && serial_out_en);

endmodule // amsp_top

/* rtl/amsp_pkg.sv */
package amsp_pkg;

    // ==================================================================
    // timing
    localparam int CLK_FREQ_MHZ     = 100;
    localparam int CLK_PERIOD_NS    = 1000 / CLK_FREQ_MHZ;
    localparam int ALL_OFF_DELAY_NS = 500;
    localparam int OPEN_GAP_NS      = 125;
    // longest off delay rounds down, least open gap rounds up
    localparam int OFF_CYC  = ALL_OFF_DELAY_NS / CLK_PERIOD_NS;
    localparam int OPEN_CYC = (OPEN_GAP_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int ON_CYC   = OFF_CYC + OPEN_CYC;
    localparam int TMR_W    = 7;
    localparam logic [TMR_W-1:0] OFF_LOAD  = TMR_W'(OFF_CYC - 2);
    localparam logic [TMR_W-1:0] OPEN_LOAD = TMR_W'(OPEN_CYC - 1);

    // ==================================================================
    // word and result layout
    localparam int WORD_W = 4;
    localparam int EN_POS = 3;
    localparam int CODE_W = 3;
    localparam int CHAN_N = 8;
    localparam int RES_W  = 12;
    localparam int FC_W   = 4;
    localparam logic [FC_W-1:0] FC_NULL       = 4'h1;
    localparam logic [FC_W-1:0] FC_SAMPLE_END = 4'h2;
    localparam logic [FC_W-1:0] FC_LAST       = 4'he;
    localparam logic [FC_W-1:0] FC_MAX        = 4'hf;
    localparam logic [1:0]      BUF_FULL      = 2'h2;

    // ==================================================================
    // types
    typedef enum logic [1:0] {
        MUX_IDLE,
        MUX_BREAK,
        MUX_GAP,
        MUX_HOLD
    } amsp_mux_state_t;

    typedef struct packed {
        logic             valid;
        logic [RES_W-1:0] data;
    } amsp_result_t;

    typedef struct packed {
        logic                       sclk;
        logic                       ch_sel;
        logic                       cv_sel;
        logic [WORD_W-1:0]          word;
        logic [WORD_W-1:0]          latched;
        amsp_mux_state_t            mux;
        logic [TMR_W-1:0]           tmr;
        logic [CHAN_N-1:0]          chan;
        logic [FC_W-1:0]            fc;
        logic                       power;
        logic                       sample;
        logic                       start;
        logic                       want;
        logic                       loaded;
        logic [RES_W-1:0]           sh;
        logic                       sout;
        logic                       soe;
        logic [1:0][RES_W-1:0]      fifo;
        logic                       wp;
        logic                       rp;
        logic [1:0]                 cnt;
        logic                       rdy;
    } amsp_state_t;

    function automatic logic [CHAN_N-1:0] amsp_decode(
        input logic [CODE_W-1:0] code
    );
        amsp_decode       = '0;
        amsp_decode[code] = 1'b1;
    endfunction

endpackage

/* bench/amsp_master_model.sv */
// ======================================================================
// serial master on the far side of the link
module amsp_master_model (
    input  logic clk,
    input  logic serial_out,
    input  logic serial_out_en,
    output logic shift_clk,
    output logic channel_select_n,
    output logic converter_select_n,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // clk cycles per shift-clock phase, four times the one-cycle minimum for margin
    localparam int HALF = 4;

    // shift clock parks high between frames
    initial begin
        shift_clk          = 1'b1;
        channel_select_n   = 1'b1;
        converter_select_n = 1'b1;
        serial_in          = 1'b0;
    end

    task automatic half_cycle(input logic level);
        shift_clk = level;
        repeat (HALF) @(negedge clk);
    endtask

    task automatic xfer(input logic [7:0] bits, input int nb,
                        output logic [13:0] got, output logic en_ok);
        got   = '0;
        en_ok = 1'b1;
        @(negedge clk);
        for (int i = nb - 1; i >= 0; i--) begin
            serial_in = bits[i];
            half_cycle(1'b0);
            half_cycle(1'b1);
        end
        channel_select_n   = 1'b0;
        converter_select_n = 1'b0;
        repeat (70) @(negedge clk);
        for (int i = 0; i < 14; i++) begin
            // line released: a changing pattern, starting from the inverse of the last bit
            serial_in = ~serial_in;
            half_cycle(1'b0);
            got   = {got[12:0], serial_out};
            en_ok = en_ok & serial_out_en;
            half_cycle(1'b1);
        end
        channel_select_n   = 1'b1;
        converter_select_n = 1'b1;
        repeat (HALF) @(negedge clk);
    endtask
endmodule // amsp_master_model

/* bench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import amsp_pkg::*;

    logic         clk, resetn, shift_clk, channel_select_n;
    logic         converter_select_n, serial_in, serial_out, serial_out_en;
    logic         result_ready, convert_start, converter_power;
    logic         sample_active;
    logic [7:0]   channel_enable;
    amsp_result_t res_in;
    int           n_errors = 0;
    int           check_count = 0;
    int           n_conv = 0;

    amsp_top dut (
        .clk(clk), .resetn(resetn), .shift_clk(shift_clk),
        .channel_select_n(channel_select_n),
        .converter_select_n(converter_select_n),
        .serial_in(serial_in), .result_in(res_in),
        .result_ready(result_ready), .convert_start(convert_start),
        .converter_power(converter_power),
        .sample_active(sample_active), .channel_enable(channel_enable),
        .serial_out(serial_out), .serial_out_en(serial_out_en)
    );

    amsp_master_model master (
        .clk(clk), .serial_out(serial_out), .serial_out_en(serial_out_en),
        .shift_clk(shift_clk), .channel_select_n(channel_select_n),
        .converter_select_n(converter_select_n), .serial_in(serial_in)
    );

    always #5 clk = ~clk;

    always @(posedge clk) begin
        if (convert_start === 1'b1) begin
            n_conv <= n_conv + 1;
        end
    end

    // ==================================================================
    // helpers
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // converter core side: offer a word, give up after a few cycles
    task automatic push(input logic [11:0] d, output logic ok);
        int n;
        n = 0;
        @(negedge clk);
        res_in.valid = 1'b1;
        res_in.data  = d;
        while (result_ready !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        ok = result_ready;
        @(negedge clk);
        res_in.valid = 1'b0;
    endtask

    task automatic run(input logic [7:0] bits, input int nb,
                       input logic [11:0] res);
        logic [7:0]  prev;
        logic [7:0]  want;
        logic [13:0] got;
        logic        en_ok;
        int          conv0;
        prev  = channel_enable;
        want  = bits[3] ? (8'h01 << bits[2:0]) : 8'h00;
        conv0 = n_conv;
        fork
            master.xfer(bits, nb, got, en_ok);
            begin
                @(negedge channel_select_n);
                // the first edge after the fall is edge 0; channels drop at 49
                repeat (49) @(posedge clk);
                #1 chk("ce_before_off", prev, channel_enable);
                @(posedge clk);
                #1 chk("ce_off", 8'h00, channel_enable);
                repeat (12) @(posedge clk);
                #1 chk("ce_gap", 8'h00, channel_enable);
                @(posedge clk);
                #1 chk("ce_on", want, channel_enable);
                chk("sampling", 1'b1, sample_active);
            end
        join
        chk("result", {2'b00, res}, got);
        chk("oe_framed", 1'b1, en_ok);
        chk("conv_starts", 16'(conv0 + 1), 16'(n_conv));
        repeat (2) @(negedge clk);
        chk("oe_idle", 1'b0, serial_out_en);
        chk("power_off", 1'b0, converter_power);
        chk("ce_kept", want, channel_enable);
    endtask

    // ==================================================================
    // scenarios
    task automatic t_channels();
        logic        ok;
        logic [11:0] d;
        for (int ch = 0; ch < 8; ch++) begin
            d = 12'h05a3 ^ 12'(ch * 273);
            push(d, ok);
            chk("push_ok", 1'b1, ok);
            // odd channels carry three leading junk bits
            run({4'h5, 1'b1, 3'(ch)}, (ch % 2) ? 7 : 4, d);
        end
        $display("test channels done");
    endtask

    task automatic t_off();
        logic ok;
        push(12'h0800, ok);
        run(8'h05, 4, 12'h0800);
        $display("test all_off done");
    endtask

    task automatic t_buffer();
        logic ok;
        push(12'h00a5, ok);
        chk("push_a", 1'b1, ok);
        push(12'h03c3, ok);
        chk("push_b", 1'b1, ok);
        chk("ready_full", 1'b0, result_ready);
        push(12'h0fff, ok);
        chk("push_refused", 1'b0, ok);
        run(8'h0b, 4, 12'h00a5);
        // the pending word is dropped when the converter select rises
        run(8'h0c, 4, 12'h0000);
        chk("ready_again", 1'b1, result_ready);
        $display("test buffer done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clk    = 1'b0;
        resetn = 1'b0;
        res_in = '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        chk("oe_reset", 1'b0, serial_out_en);
        t_channels();
        t_off();
        t_buffer();
        give_verdict();
    end

    // eleven exchanges of about 250 clk each fit well inside this
    initial begin
        repeat (10000) @(posedge clk);
        n_errors++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule // tb_top
